// ==== rtl/rdt_pkg.sv ====
// Shared constants for the reload down timer and its prescaler.
package rdt_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    localparam logic [15:0] ADDR_PRESCALE  = 16'hFF11;
    localparam logic [15:0] ADDR_PRIORITY  = 16'hFF21;
    localparam logic [15:0] ADDR_IRQ_EN    = 16'hFF24;
    localparam logic [15:0] ADDR_IRQ_FLAG  = 16'hFF28;
    localparam logic [15:0] ADDR_CONTROL   = 16'hFF38;
    localparam logic [15:0] ADDR_RELOAD    = 16'hFF39;
    localparam logic [15:0] ADDR_READBACK  = 16'hFF3A;

    localparam int BIT_PRESCALE_GATE = 3;
    localparam int BIT_SELECT_LO     = 0;
    localparam int BIT_PRIORITY_LO   = 6;
    localparam int BIT_IRQ_ENABLE    = 7;
    localparam int BIT_IRQ_FLAG      = 7;
    localparam int BIT_CLK_OUT_EN    = 2;
    localparam int BIT_PRESET        = 1;
    localparam int BIT_RUN           = 0;

    localparam logic [7:0]  RESET_RELOAD    = 8'hFF;
    localparam logic [7:0]  RESET_COUNT     = 8'hFF;
    localparam logic [2:0]  RESET_SELECT    = 3'h0;
    localparam logic [1:0]  RESET_PRIORITY  = 2'h0;
    localparam logic [23:0] TIMER_IRQ_VECTOR = 24'h000018;

endpackage : rdt_pkg

// ==== rtl/rdt_prescaler.sv ====
// Prescaler that divides the oscillator clock by two to 256 for the timer.
`timescale 1ns/1ns
module rdt_prescaler
    import rdt_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       osc_on,
    input  wire logic       gate,
    input  wire logic [2:0] select,
    output logic            tick
);

    if (DIV_W < 8) begin : g_div_check
        $error("rdt_prescaler needs at least eight divider bits");
    end

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic             tick_reg;
    logic             tick_next;
    logic [DIV_W-1:0] tap_mask;

    // The divider stops while the oscillator is off, so no new tick is made then; a tick registered just before can still leave in the first cycle off.
    always_comb begin
        tap_mask  = DIV_W'((9'h002 << select) - 9'h001);
        div_next  = div_reg;
        tick_next = 1'b0;
        if (gate && osc_on) begin
            div_next  = div_reg + 1'b1;
            tick_next = ((div_reg & tap_mask) == tap_mask);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : rdt_prescaler

// ==== rtl/rdt_timer.sv ====
// Eight-bit reload down timer that sources the serial baud clock.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns

// How it works
// - Reload register is readable and writable and resets to all ones.
// - Writing one to preset copies the reload value into the counter at once.
// - Underflow while counting reloads the counter from the reload register.
// - Run set lets each prescaled tick decrement the counter.
// - Run clear stops counting and keeps the count for a later resume.
// - The present count is readable at any time through a read-only port.
// - Every underflow sets the underflow flag.
// - The interrupt reaches the CPU only while its enable bit is set.
// - A two-bit priority field gives the interrupt level zero to three.
// - The interrupt is presented with a fixed vector address.
// - Each underflow toggles a divide-by-two serial clock.
// - The serial clock leaves the block only while its output enable is set.
// - A three-bit select picks oscillator divide by two up to 256.
// - The prescaler gate bit passes prescaled ticks only when set.
// - A reload value of zero gives an underflow every prescaled tick.
// - Nothing advances while the high-speed oscillator is off.
// - Writing one to the underflow flag clears it, zero does nothing.
// - Request needs flag, enable, and priority above the CPU mask level.
// - The preset bit is write-only and always reads as zero.
module rdt_timer
    import rdt_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              hs_osc_on,
    input  wire logic [1:0]        cpu_mask_level,
    output logic                   irq_req,
    output logic      [1:0]        irq_level,
    output logic      [23:0]       irq_vector,
    output logic                   serial_clk_out
);

    // The count is read back in one bus access, so it must be exactly as wide as the bus.
    if (CNT_W != DATA_W) begin : g_width_check
        $error("rdt_timer counter width must match the data bus width");
    end

    // Register decode shared by the write and read paths.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction : hit

    // Oscillator status comes from another part of the chip and is synchronised.
    // Only the second stage is read, so a metastable first stage never reaches the counter.
    logic osc_sync1_reg;
    logic osc_sync2_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_sync1_reg <= 1'b0;
            osc_sync2_reg <= 1'b0;
        end else begin
            osc_sync1_reg <= hs_osc_on;
            osc_sync2_reg <= osc_sync1_reg;
        end
    end

    // Software control registers.
    // The preset bit is a strobe and is not stored, so it can never read back as one.
    logic [2:0]       select_reg;
    logic [2:0]       select_next;
    logic             gate_reg;
    logic             gate_next;
    logic [1:0]       priority_reg;
    logic [1:0]       priority_next;
    logic             irq_en_reg;
    logic             irq_en_next;
    logic             clk_out_en_reg;
    logic             clk_out_en_next;
    logic             run_reg;
    logic             run_next;
    logic [CNT_W-1:0] reload_reg;
    logic [CNT_W-1:0] reload_next;
    logic             preset_hit;

    always_comb begin
        select_next     = select_reg;
        gate_next       = gate_reg;
        priority_next   = priority_reg;
        irq_en_next     = irq_en_reg;
        clk_out_en_next = clk_out_en_reg;
        run_next        = run_reg;
        reload_next     = reload_reg;
        preset_hit      = 1'b0;
        if (wr) begin
            if (hit(addr, ADDR_PRESCALE)) begin
                select_next = wdata[BIT_SELECT_LO +: 3];
                gate_next   = wdata[BIT_PRESCALE_GATE];
            end
            if (hit(addr, ADDR_PRIORITY)) begin
                priority_next = wdata[BIT_PRIORITY_LO +: 2];
            end
            if (hit(addr, ADDR_IRQ_EN)) begin
                irq_en_next = wdata[BIT_IRQ_ENABLE];
            end
            if (hit(addr, ADDR_CONTROL)) begin
                clk_out_en_next = wdata[BIT_CLK_OUT_EN];
                run_next        = wdata[BIT_RUN];
                preset_hit      = wdata[BIT_PRESET];
            end
            if (hit(addr, ADDR_RELOAD)) begin
                reload_next = wdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            select_reg     <= RESET_SELECT;
            gate_reg       <= 1'b0;
            priority_reg   <= RESET_PRIORITY;
            irq_en_reg     <= 1'b0;
            clk_out_en_reg <= 1'b0;
            run_reg        <= 1'b0;
            reload_reg     <= RESET_RELOAD;
        end else begin
            select_reg     <= select_next;
            gate_reg       <= gate_next;
            priority_reg   <= priority_next;
            irq_en_reg     <= irq_en_next;
            clk_out_en_reg <= clk_out_en_next;
            run_reg        <= run_next;
            reload_reg     <= reload_next;
        end
    end

    // Prescaled tick source.
    logic tick;

    rdt_prescaler #(
        .DIV_W (8)
    ) u_prescaler (
        .clk    (clk),
        .rstn   (rstn),
        .osc_on (osc_sync2_reg),
        .gate   (gate_reg),
        .select (select_reg),
        .tick   (tick)
    );

    // Down counter. A preset in the same cycle as a tick wins, since software
    // expects the counter to hold exactly the reload value after presetting.
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             underflow;

    always_comb begin
        count_next = count_reg;
        underflow  = 1'b0;
        if (preset_hit) begin
            count_next = reload_reg;
        end else if (tick && run_reg && osc_sync2_reg) begin
            if (count_reg == '0) begin
                underflow  = 1'b1;
                count_next = reload_reg;
            end else begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= RESET_COUNT;
        end else begin
            count_reg <= count_next;
        end
    end

    // Underflow flag; a fresh underflow beats a clear in the same cycle.
    logic flag_reg;
    logic flag_next;

    always_comb begin
        flag_next = flag_reg;
        if (wr && hit(addr, ADDR_IRQ_FLAG) && wdata[BIT_IRQ_FLAG]) begin
            flag_next = 1'b0;
        end
        if (underflow) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Interrupt request toward the CPU.
    // The CPU mask level comes from logic on this clock, so it is compared unsynchronised.
    // The vector never changes but is registered so that every output leaves a flip-flop.
    logic        irq_req_reg;
    logic        irq_req_next;
    logic [1:0]  irq_level_reg;
    logic [23:0] irq_vector_reg;

    always_comb begin
        irq_req_next = flag_reg && irq_en_reg && (priority_reg > cpu_mask_level);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_req_reg    <= 1'b0;
            irq_level_reg  <= RESET_PRIORITY;
            irq_vector_reg <= TIMER_IRQ_VECTOR;
        end else begin
            irq_req_reg    <= irq_req_next;
            irq_level_reg  <= priority_reg;
            irq_vector_reg <= TIMER_IRQ_VECTOR;
        end
    end

    // Divide-by-two serial clock. The toggle keeps running while output is
    // disabled, so enabling it mid-stream may give one short first phase.
    logic toggle_reg;
    logic toggle_next;
    logic sclk_reg;
    logic sclk_next;

    always_comb begin
        toggle_next = underflow ? ~toggle_reg : toggle_reg;
        sclk_next   = toggle_next && clk_out_en_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            toggle_reg <= 1'b0;
            sclk_reg   <= 1'b0;
        end else begin
            toggle_reg <= toggle_next;
            sclk_reg   <= sclk_next;
        end
    end

    // Read path: data stand only in the cycle after the read strobe.
    // Unmapped addresses and unused bits read as zero so no stale value leaks out.
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        rdata_next = '0;
        if (rd) begin
            if (hit(addr, ADDR_PRESCALE)) begin
                rdata_next[BIT_PRESCALE_GATE]   = gate_reg;
                rdata_next[BIT_SELECT_LO +: 3]  = select_reg;
            end
            if (hit(addr, ADDR_PRIORITY)) begin
                rdata_next[BIT_PRIORITY_LO +: 2] = priority_reg;
            end
            if (hit(addr, ADDR_IRQ_EN)) begin
                rdata_next[BIT_IRQ_ENABLE] = irq_en_reg;
            end
            if (hit(addr, ADDR_IRQ_FLAG)) begin
                rdata_next[BIT_IRQ_FLAG] = flag_reg;
            end
            if (hit(addr, ADDR_CONTROL)) begin
                rdata_next[BIT_CLK_OUT_EN] = clk_out_en_reg;
                rdata_next[BIT_PRESET]     = 1'b0;
                rdata_next[BIT_RUN]        = run_reg;
            end
            if (hit(addr, ADDR_RELOAD)) begin
                rdata_next = reload_reg;
            end
            if (hit(addr, ADDR_READBACK)) begin
                rdata_next = count_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata          = rdata_reg;
    assign irq_req        = irq_req_reg;
    assign irq_level      = irq_level_reg;
    assign irq_vector     = irq_vector_reg;
    assign serial_clk_out = sclk_reg;

endmodule : rdt_timer

// ==== tb/rdt_timer_props.sv ====
// Port-level assertions for the reload down timer.
`timescale 1ns/1ns
module rdt_timer_props
    import rdt_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              hs_osc_on,
    input wire logic [1:0]        cpu_mask_level,
    input wire logic              irq_req,
    input wire logic [1:0]        irq_level,
    input wire logic [23:0]       irq_vector,
    input wire logic              serial_clk_out
);
    logic [7:0] reload_copy_reg;
    logic       en_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadows let the properties name register contents without reaching inside.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reload_copy_reg <= RESET_RELOAD;
            en_reg          <= 1'b0;
        end else if (wr && addr == ADDR_RELOAD) begin
            reload_copy_reg <= wdata;
        end else if (wr && addr == ADDR_IRQ_EN) begin
            en_reg <= wdata[BIT_IRQ_ENABLE];
        end
    end
    sequence s_read(logic [15:0] a);
        rd && addr == a;
    endsequence
    sequence s_preset;
        wr && addr == ADDR_CONTROL && wdata[BIT_PRESET] && !wdata[BIT_RUN];
    endsequence
    sequence s_out_off;
        (wr && addr == ADDR_CONTROL && !wdata[BIT_CLK_OUT_EN]) ##1 !(wr && addr == ADDR_CONTROL);
    endsequence
    a_vector_fixed: assert property (irq_vector == TIMER_IRQ_VECTOR)
        else $error("vector wrong");
    a_reload_back: assert property (s_read(ADDR_RELOAD) |=> rdata == reload_copy_reg)
        else $error("reload readback wrong");
    a_preset_count: assert property (s_preset ##2 s_read(ADDR_READBACK) |=> rdata == reload_copy_reg)
        else $error("preset not loaded");
    a_preset_reads0: assert property (s_read(ADDR_CONTROL) |=> rdata[7:3] == 5'h00 && !rdata[BIT_PRESET])
        else $error("control readback wrong");
    a_irq_needs_en: assert property (irq_req |-> $past(en_reg))
        else $error("irq without enable");
    a_irq_over_mask: assert property (irq_req |-> irq_level > $past(cpu_mask_level))
        else $error("irq not above mask");
    a_level_follow: assert property (wr && addr == ADDR_PRIORITY |=> ##1 irq_level == $past(wdata[7:6], 2))
        else $error("level wrong");
    a_clkout_gated: assert property (s_out_off |=> !serial_clk_out)
        else $error("clock out not gated");
    a_osc_off_hold: assert property ((!hs_osc_on && !wr)[*8] |=> $stable(serial_clk_out))
        else $error("runs without oscillator");
    a_serial_low: assert property ($rose(rstn) |-> !serial_clk_out)
        else $error("serial clock not low");
endmodule : rdt_timer_props

bind rdt_timer rdt_timer_props #(.CNT_W(CNT_W)) i_props (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hs_osc_on(hs_osc_on), .cpu_mask_level(cpu_mask_level),
    .irq_req(irq_req), .irq_level(irq_level), .irq_vector(irq_vector), .serial_clk_out(serial_clk_out));

// ==== tb/rdt_baud_sink.sv ====
// Serial side model that times the baud clock it is given.
`timescale 1ns/1ns
module rdt_baud_sink (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        baud_in,
    output logic      [15:0] period
);
    logic        last_reg;
    logic [15:0] gap_reg;
    // The serial side acts on rising edges only, so only those are timed.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_reg <= 1'b0;
            gap_reg  <= 16'h0000;
            period   <= 16'h0000;
        end else begin
            last_reg <= baud_in;
            gap_reg  <= (baud_in && !last_reg) ? 16'h0001 : gap_reg + 16'h0001;
            if (baud_in && !last_reg) begin
                period <= gap_reg;
            end
        end
    end
endmodule : rdt_baud_sink

// ==== tb/rdt_timer_bench.sv ====
// Self-checking bench for the reload down timer.
`timescale 1ns/1ns
module rdt_timer_bench;
    import rdt_pkg::*;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [ADDR_W-1:0] addr = 16'h0000;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              hs_osc_on = 1'b1;
    logic [1:0]        cpu_mask_level = 2'h0;
    logic [DATA_W-1:0] rdata;
    logic              irq_req;
    logic [1:0]        irq_level;
    logic [23:0]       irq_vector;
    logic              serial_clk_out;
    logic [15:0]       period;
    logic [7:0]        v;
    int                bad_count = 0;
    int                cmp_count = 0;

    always #50 clk = ~clk;

    rdt_timer i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .hs_osc_on(hs_osc_on), .cpu_mask_level(cpu_mask_level), .irq_req(irq_req), .irq_level(irq_level),
        .irq_vector(irq_vector), .serial_clk_out(serial_clk_out));
    rdt_baud_sink i_sink (.clk(clk), .rstn(rstn), .baud_in(serial_clk_out), .period(period));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk(d, e);
    endtask : rd_chk
    // Reload first, gate and select next, then preset, run last, as software must.
    task automatic start(input logic [2:0] sel, input logic [7:0] rl);
        wr_reg(ADDR_RELOAD, rl);
        wr_reg(ADDR_PRESCALE, {5'h01, sel});
        wr_reg(ADDR_CONTROL, 8'h06);
        wr_reg(ADDR_CONTROL, 8'h05);
    endtask : start
    task automatic t_reset;
        chk(serial_clk_out, 1'b0);
        rd_chk(ADDR_RELOAD, 8'hFF);
        rd_chk(ADDR_READBACK, 8'hFF);
        rd_chk(ADDR_PRESCALE, 8'h00);
        rd_chk(ADDR_IRQ_FLAG, 8'h00);
        rd_chk(ADDR_CONTROL, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_regs;
        wr_reg(ADDR_RELOAD, 8'h5A);
        rd_chk(ADDR_RELOAD, 8'h5A);
        wr_reg(ADDR_PRESCALE, 8'hFF);
        rd_chk(ADDR_PRESCALE, 8'h0F);
        wr_reg(ADDR_CONTROL, 8'hFE);
        rd_chk(ADDR_READBACK, 8'h5A);
        rd_chk(ADDR_CONTROL, 8'h04);
        wr_reg(ADDR_READBACK, 8'h00);
        rd_chk(ADDR_READBACK, 8'h5A);
        wr_reg(16'hFF30, 8'hFF);
        rd_chk(16'hFF30, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_hold;
        start(3'h0, 8'h40);
        repeat (10) @(posedge clk);
        wr_reg(ADDR_CONTROL, 8'h00);
        rd_reg(ADDR_READBACK, v);
        chk(v inside {[8'h38:8'h3F]}, 1'b1);
        repeat (20) @(posedge clk);
        rd_chk(ADDR_READBACK, v);
        wr_reg(ADDR_PRESCALE, 8'h00);
        wr_reg(ADDR_CONTROL, 8'h01);
        repeat (20) @(posedge clk);
        rd_chk(ADDR_READBACK, v);
        @(posedge clk);
        hs_osc_on <= 1'b0;
        repeat (4) @(posedge clk);
        wr_reg(ADDR_PRESCALE, 8'h08);
        repeat (20) @(posedge clk);
        rd_chk(ADDR_READBACK, v);
        @(posedge clk);
        hs_osc_on <= 1'b1;
        wr_reg(ADDR_CONTROL, 8'h00);
        $display("t_hold done");
    endtask : t_hold
    task automatic t_underflow;
        start(3'h0, 8'h00);
        repeat (20) @(posedge clk);
        rd_chk(ADDR_READBACK, 8'h00);
        rd_chk(ADDR_IRQ_FLAG, 8'h80);
        chk(period, 16'h0004);
        @(posedge clk);
        hs_osc_on <= 1'b0;
        repeat (4) @(posedge clk);
        v = serial_clk_out;
        repeat (12) @(posedge clk);
        chk(serial_clk_out, v);
        hs_osc_on <= 1'b1;
        wr_reg(ADDR_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        chk(serial_clk_out, 1'b0);
        wr_reg(ADDR_IRQ_FLAG, 8'h00);
        rd_chk(ADDR_IRQ_FLAG, 8'h80);
        wr_reg(ADDR_IRQ_FLAG, 8'h80);
        rd_chk(ADDR_IRQ_FLAG, 8'h00);
        $display("t_underflow done");
    endtask : t_underflow
    task automatic t_prescale;
        for (int s = 0; s < 8; s++) begin
            start(s[2:0], 8'h01);
            repeat (24 << s) @(posedge clk);
            chk(period, 16'h0008 << s);
        end
        wr_reg(ADDR_CONTROL, 8'h00);
        $display("t_prescale done");
    endtask : t_prescale
    task automatic t_irq;
        start(3'h0, 8'h00);
        repeat (6) @(posedge clk);
        wr_reg(ADDR_CONTROL, 8'h00);
        cpu_mask_level <= 2'h1;
        wr_reg(ADDR_IRQ_EN, 8'h80);
        rd_chk(ADDR_IRQ_EN, 8'h80);
        for (int p = 0; p < 4; p++) begin
            wr_reg(ADDR_PRIORITY, {p[1:0], 6'h00});
            repeat (2) @(posedge clk);
            chk(irq_level, p[1:0]);
            chk(irq_req, p > 1);
        end
        wr_reg(ADDR_IRQ_EN, 8'h00);
        repeat (2) @(posedge clk);
        chk(irq_req, 1'b0);
        chk(irq_vector, TIMER_IRQ_VECTOR);
        $display("t_irq done");
    endtask : t_irq
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_regs;
        t_hold;
        t_underflow;
        t_prescale;
        t_irq;
        test_done;
    end
    // The slowest divider setting dominates the run, so the limit leaves it a wide margin.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        test_done;
    end
endmodule : rdt_timer_bench
